// file: inc/sfel_pkg.sv
package sfel_pkg;
	// timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int PROG_TIME_NS = 2000;
	localparam int ERASE_TIME_NS = 10000;
	localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
	localparam int ERASE_CYCLES = ERASE_TIME_NS / CLK_PERIOD_NS;
	localparam int OP_CNT_W = 12;
	localparam int LAT_CLKS = 4;
	// geometry
	localparam int PAGE_BYTES = 512;
	localparam int PAGE_AW = 9;
	localparam int ADDR_BITS = 24;
	localparam int AXI_AW = 8;
	// serial instructions
	localparam logic [7:0] OP_WRR = 8'h01;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_CLSR = 8'h30;
	localparam logic [7:0] OP_RDCR = 8'h35;
	localparam logic [7:0] OP_OTPP = 8'h42;
	localparam logic [7:0] OP_DUAL_READ = 8'hBB;
	localparam logic [7:0] OP_SE = 8'hD8;
	localparam logic [7:0] OP_QUAD_READ = 8'hEB;
	localparam logic [7:0] OP_DDR_QREAD = 8'hED;
	// status1 bits
	localparam int SR_WIP = 0;
	localparam int SR_WEL = 1;
	localparam int SR_EERR = 5;
	localparam int SR_PERR = 6;
	localparam logic [7:0] SR_BP_MASK = 8'h1C;
	localparam logic [7:0] SR_WR_MASK = 8'h1C;
	// config1 bits
	localparam int CR_FREEZE = 0;
	localparam int CR_QUAD = 1;
	localparam int CR_PRO = 5;
	localparam int CR_FOURWIRE = 6;
	localparam logic [7:0] CRNV_WR_MASK = 8'h2C;
	localparam logic [7:0] CRNV_LOCK_MASK = 8'h2C;
	localparam logic [7:0] CRV_WR_MASK = 8'h43;
	localparam logic [7:0] CRV_LOCK_MASK = 8'h01;
	// reset values
	localparam logic [7:0] STATUS1_NONVOLATILE_RST = 8'h00;
	localparam logic [7:0] STATUS1_VOLATILE_RST = 8'h00;
	localparam logic [7:0] CONFIG1_NONVOLATILE_RST = 8'h00;
	localparam logic [7:0] CONFIG1_VOLATILE_RST = 8'h00;
	// register map
	localparam logic [AXI_AW-1:0] REG_FLASH_STATUS = 8'h00;
	localparam logic [AXI_AW-1:0] REG_IRQ_STATUS = 8'h04;
	localparam logic [AXI_AW-1:0] REG_IRQ_CLEAR = 8'h08;
	localparam logic [AXI_AW-1:0] REG_IRQ_ENABLE = 8'h0C;
	localparam logic [AXI_AW-1:0] REG_CONTROL = 8'h10;
	localparam int IRQ_OP_DONE = 0;
	localparam int IRQ_PERR = 1;
	localparam int IRQ_EERR = 2;
	localparam int IRQ_CMD_END = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// {io_in, cs_n, sck}
	localparam logic [5:0] PIN_SYNC_RST = 6'h02;
	typedef enum logic [6:0] {
		PH_IDLE = 7'h01,
		PH_INSTR = 7'h02,
		PH_ADDR = 7'h04,
		PH_LAT = 7'h08,
		PH_DIN = 7'h10,
		PH_DOUT = 7'h20,
		PH_SKIP = 7'h40
	} sfel_phase_type;
endpackage : sfel_pkg

// file: verif/sfel_host.sv
`timescale 1ns/1ps
`default_nettype none
module sfel_host (
	output logic sck,
	output logic cs_n,
	output logic [3:0] io_in,
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe_n
);
	logic mosi;
	logic rel;
	logic tog;
	// released lines show the inverse of the last bit or a moving pattern
	always_comb begin
		io_in[0] = !io_oe_n[0] ? io_out[0] : (rel ? !mosi : mosi);
		for (int i = 1; i < 4; i++) begin
			io_in[i] = !io_oe_n[i] ? io_out[i] : tog ^ i[0];
		end
	end
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
		rel = 1'b1;
		tog = 1'b0;
		forever #5 tog = !tog;
	end
	task automatic xfer(input logic [63:0] tx, input int ntx, input int nrx, output logic [31:0] rx);
		rx = '0;
		#1.3;
		cs_n = 1'b0;
		rel = 1'b0;
		for (int i = 8 * ntx - 1; i >= 0; i--) begin
			mosi = tx[i];
			#62.5 sck = 1'b1;
			#62.5 sck = 1'b0;
		end
		for (int i = 0; i < 8 * nrx; i++) begin
			#62.5 sck = 1'b1;
			rx = {rx[30:0], io_in[1]};
			#62.5 sck = 1'b0;
		end
		#62.5 cs_n = 1'b1;
		rel = 1'b1;
		#200;
	endtask : xfer
endmodule : sfel_host
`default_nettype wire

// file: verif/sfel_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sfel_monitor import sfel_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cs_n,
	input wire logic [3:0] io_oe_n,
	input wire logic irq,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic wr_take;
	assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	chk_idle_release: assert property (cs_n [*8] |-> io_oe_n == 4'hF)
		else $error("data lines driven while deselected");
	chk_drive_framed: assert property ($fell(io_oe_n[1]) |-> $past(cs_n, 4) == 1'b0)
		else $error("output driven outside a command");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	chk_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > REG_CONTROL
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_wr_answer: assert property (wr_take |-> !s_axi_bvalid ##2 s_axi_bvalid)
		else $error("write answer not two edges after take");
	chk_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	chk_ro_write: assert property (wr_take && s_axi_awaddr == REG_FLASH_STATUS
		|-> ##2 s_axi_bresp == RESP_SLVERR)
		else $error("read-only write not refused");
	cover property (io_oe_n == 4'hD);
	cover property ($rose(irq));
	cover property ($fell(irq));
	cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : sfel_monitor
bind sfel_flash_ctrl sfel_monitor mon (.aclk, .aresetn, .cs_n, .io_oe_n, .irq, .s_axi_awvalid,
	.s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp);
`default_nettype wire

// file: verif/spi_flash_error_and_freeze_lock_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spi_flash_error_and_freeze_lock_tb import sfel_pkg::*;;
	logic aclk, aresetn, sck, cs_n, irq;
	logic [3:0] io_in, io_out, io_oe_n, s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, rx;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	int err_total, n_compared;
	sfel_flash_ctrl dut (.aclk, .aresetn, .sck, .cs_n, .io_in, .io_out, .io_oe_n, .irq,
		.s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp);
	sfel_host host (.sck, .cs_n, .io_in, .io_out, .io_oe_n);
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
	endtask : axw
	task automatic axr(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : axr
	task automatic rd(input logic [31:0] m, input logic [31:0] e);
		axr(REG_FLASH_STATUS);
		chk(d & m, e);
	endtask : rd
	task automatic sp(input logic [63:0] tx, input int n, input int nr);
		host.xfer(tx, n, nr, rx);
		@(posedge aclk);
	endtask : sp
	// wait out the program or erase that a command may have launched
	task automatic idle;
		repeat (10) @(posedge aclk);
		do axr(REG_CONTROL); while (d[1] !== 1'b0);
	endtask : idle
	task automatic ci(input logic e);
		repeat (4) @(posedge aclk);
		chk({31'h0, irq}, {31'h0, e});
	endtask : ci
	initial begin
		#300000;
		err_total++;
		results;
	end
	initial begin
		aresetn = 1'b0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		err_total = 0;
		n_compared = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(32'hFFFFFFFF, {CONFIG1_NONVOLATILE_RST, CONFIG1_VOLATILE_RST, STATUS1_NONVOLATILE_RST, STATUS1_VOLATILE_RST});
		axr(8'h14);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		axw(REG_FLASH_STATUS, 32'h0);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		axw(REG_IRQ_ENABLE, 32'h6);
		sp({OP_WREN}, 1, 0);
		sp({OP_WRR, 8'h08, 8'h2C}, 3, 0);
		idle;
		rd(32'h2C011C1C, 32'h2C000808);
		// bottom range now protected
		sp({OP_WREN}, 1, 0);
		sp({OP_PP, 24'h000000, 8'hA5}, 5, 0);
		idle;
		rd(32'h61, 32'h41);
		ci(1'b1);
		sp({OP_RDSR}, 1, 1);
		chk(rx & 32'h61, 32'h41);
		sp({OP_CLSR}, 1, 0);
		idle;
		rd(32'h61, 32'h0);
		axw(REG_IRQ_CLEAR, 32'hF);
		ci(1'b0);
		sp({OP_WREN}, 1, 0);
		sp({OP_SE, 24'h000000}, 4, 0);
		idle;
		rd(32'h61, 32'h21);
		ci(1'b1);
		axw(REG_IRQ_ENABLE, 32'h0);
		ci(1'b0);
		sp({OP_CLSR}, 1, 0);
		idle;
		rd(32'h61, 32'h0);
		axw(REG_IRQ_CLEAR, 32'hF);
		sp({OP_WREN}, 1, 0);
		sp({OP_PP, 24'hFF0000, 32'h0123ABCD}, 8, 0);
		idle;
		rd(32'h61, 32'h0);
		sp({OP_READ, 24'hFF0000}, 4, 4);
		chk(rx, 32'h0123ABCD);
		axw(REG_CONTROL, 32'h1);
		sp({OP_WREN}, 1, 0);
		sp({OP_PP, 24'hFF0100, 8'h5A}, 5, 0);
		idle;
		rd(32'h61, 32'h41);
		axr(REG_CONTROL);
		chk(d & 32'h1, 32'h0);
		sp({OP_CLSR}, 1, 0);
		idle;
		sp({OP_WREN}, 1, 0);
		sp({OP_WRR, 8'h08, 8'h2D}, 3, 0);
		idle;
		sp({OP_WREN}, 1, 0);
		sp({OP_WRR, 8'h00, 8'h00}, 3, 0);
		idle;
		rd(32'h2C011C1C, 32'h2C010808);
		axw(REG_IRQ_CLEAR, 32'hF);
		axw(REG_IRQ_ENABLE, 32'h2);
		ci(1'b0);
		sp({OP_WREN}, 1, 0);
		sp({OP_OTPP, 24'h000010, 8'h00}, 5, 0);
		idle;
		rd(32'h61, 32'h41);
		ci(1'b1);
		sp({OP_CLSR}, 1, 0);
		idle;
		rd(32'h61, 32'h0);
		results;
	end
endmodule : spi_flash_error_and_freeze_lock_tb
`default_nettype wire

// file: verilog/sfel_flash_ctrl.sv
// Notes on behaviour
// - A failed or protected program or erase is abandoned and sets its error flag plus write_in_progress.
// - Error flags and write_in_progress stay set until the clear-status command returns to standby.
// - With the freeze bit set, block-protection bits 4..2 of both status1 copies cannot change.
// - With freeze set, parameter_sector_placement and protect_range_origin are locked.
// - With freeze set, protect_bits_persistence_select is locked and one-time-program writes are refused.
// - Up to 512 bytes are taken into the page buffer and programmed as one operation.
// - Double-data-rate quad reads move address and read data on both serial clock edges.
// - The link runs one, two or four data lines wide.
// - A command is everything exchanged while chip select stays low.
`timescale 1ns/1ps
`default_nettype none
module sfel_flash_ctrl import sfel_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe_n,
	output logic irq,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp
);
	typedef struct packed {
		sfel_phase_type phase;
		logic [7:0] opcode;
		logic [23:0] sh;
		logic [23:0] addr;
		logic [4:0] cnt;
		logic [9:0] nbytes;
		logic [8:0] bidx;
		logic [7:0] dout;
		logic armed;
		logic sck_q;
		logic cs_q;
		logic [7:0] status1_volatile;
		logic [7:0] status1_nonvolatile;
		logic [7:0] config1_volatile;
		logic [7:0] config1_nonvolatile;
		logic op_busy;
		logic [OP_CNT_W-1:0] op_cnt;
		logic fail_next;
		logic [3:0] io_out;
		logic [3:0] io_oe_n;
		logic [3:0] irq_stat;
		logic [3:0] irq_en;
		logic irq;
		logic aw_held;
		logic [AXI_AW-1:0] awaddr;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} sfel_core_state_type;

	sfel_core_state_type r;
	sfel_core_state_type n;
	logic [5:0] pins_s;
	logic sck_s;
	logic cs_s;
	logic [3:0] io_s;
	logic rise, fall, samp, drv, ddr, fw, frz, bad;
	logic [2:0] w;
	logic [4:0] cnt_n;
	logic [7:0] src, val;
	logic [3:0] ev, clr;
	logic buf_we;
	logic [7:0] buf_wdata;
	logic [7:0] buf_rdata;

	function automatic logic [2:0] lanes(input logic [7:0] op, input sfel_phase_type ph,
		input logic four);
		if (four) return 3'd4;
		if (ph == PH_INSTR) return 3'd1;
		if (op == OP_DUAL_READ) return 3'd2;
		if (op == OP_QUAD_READ || op == OP_DDR_QREAD) return 3'd4;
		return 3'd1;
	endfunction : lanes

	function automatic logic [23:0] shin(input logic [23:0] v, input logic [3:0] d,
		input logic [2:0] wd);
		case (wd)
			3'd4: return {v[19:0], d};
			3'd2: return {v[21:0], d[1:0]};
			default: return {v[22:0], d[0]};
		endcase
	endfunction : shin

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
		input logic [7:0] m);
		return (old & ~m) | (nw & m);
	endfunction : merge

	// for nonzero bp, region of 2^(17+bp) bytes at the top, or bottom when origin is set
	function automatic logic prot(input logic [23:0] a, input logic [2:0] bp, input logic org);
		logic [23:0] m;
		m = 24'hFFFFFF << (5'd17 + 5'(bp));
		if (bp == 3'd0) return 1'b0;
		return org ? ((a & m) == 24'h000000) : ((a & m) == m);
	endfunction : prot

	sfel_sync #(.W(6), .RST(PIN_SYNC_RST)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({io_in, cs_n, sck}),
		.q(pins_s)
	);

	sfel_page_buf #(.DEPTH(PAGE_BYTES), .AW(PAGE_AW)) u_buf (
		.aclk(aclk),
		.aresetn(aresetn),
		.we(buf_we),
		.waddr(r.bidx),
		.wdata(buf_wdata),
		.raddr(r.bidx),
		.rdata(buf_rdata)
	);

	assign sck_s = pins_s[0];
	assign cs_s = pins_s[1];
	assign io_s = pins_s[5:2];

	always_comb begin
		n = r;
		ev = 4'h0;
		clr = 4'h0;
		buf_we = 1'b0;
		buf_wdata = 8'h00;
		bad = 1'b0;
		src = 8'h00;
		val = 8'h00;
		fw = r.config1_volatile[CR_FOURWIRE];
		frz = r.config1_volatile[CR_FREEZE];
		w = lanes(r.opcode, r.phase, fw);
		ddr = (r.opcode == OP_DDR_QREAD);
		rise = sck_s & ~r.sck_q;
		fall = ~sck_s & r.sck_q;
		samp = rise | (ddr & fall & (r.phase == PH_ADDR));
		drv = (r.phase == PH_DOUT) & (fall | (ddr & rise));
		cnt_n = r.cnt + 5'(w);
		n.sck_q = sck_s;
		n.cs_q = cs_s;

		if (samp) begin
			n.sh = shin(r.sh, io_s, w);
			case (r.phase)
				PH_INSTR: begin
					n.cnt = cnt_n;
					if (cnt_n == 5'd8) begin
						n.cnt = 5'd0;
						n.opcode = n.sh[7:0];
						n.phase = PH_SKIP;
						if (r.status1_volatile[SR_WIP] && n.sh[7:0] != OP_RDSR && n.sh[7:0] != OP_RDCR &&
							n.sh[7:0] != OP_CLSR) begin
							n.phase = PH_SKIP;
						end else begin
							case (n.sh[7:0])
								OP_RDSR, OP_RDCR: n.phase = PH_DOUT;
								OP_WREN: n.status1_volatile[SR_WEL] = 1'b1;
								OP_CLSR: begin
									n.status1_volatile[SR_PERR] = 1'b0;
									n.status1_volatile[SR_EERR] = 1'b0;
									if (r.status1_volatile[SR_PERR] | r.status1_volatile[SR_EERR]) begin
										n.status1_volatile[SR_WIP] = 1'b0;
									end
								end
								OP_WRR: if (r.status1_volatile[SR_WEL]) n.phase = PH_DIN;
								OP_PP, OP_OTPP, OP_SE: if (r.status1_volatile[SR_WEL]) n.phase = PH_ADDR;
								OP_READ, OP_DUAL_READ: n.phase = PH_ADDR;
								OP_QUAD_READ, OP_DDR_QREAD: begin
									if (r.config1_volatile[CR_QUAD] | fw) n.phase = PH_ADDR;
								end
								default: n.phase = PH_SKIP;
							endcase
						end
					end
				end
				PH_ADDR: begin
					n.cnt = cnt_n;
					if (cnt_n == 5'(ADDR_BITS)) begin
						n.cnt = 5'd0;
						n.addr = n.sh;
						n.bidx = n.sh[8:0];
						case (r.opcode)
							OP_PP, OP_OTPP: n.phase = PH_DIN;
							OP_SE: begin
								n.armed = 1'b1;
								n.phase = PH_SKIP;
							end
							OP_READ: n.phase = PH_DOUT;
							default: n.phase = PH_LAT;
						endcase
					end
				end
				PH_LAT: begin
					n.cnt = r.cnt + 5'd1;
					if (r.cnt + 5'd1 == 5'(LAT_CLKS)) begin
						n.cnt = 5'd0;
						n.phase = PH_DOUT;
					end
				end
				PH_DIN: begin
					n.cnt = cnt_n;
					if (cnt_n == 5'd8) begin
						n.cnt = 5'd0;
						n.armed = 1'b1;
						if (r.opcode == OP_WRR) begin
							n.nbytes = r.nbytes + 10'd1;
							if (r.nbytes == 10'd0) begin
								n.status1_nonvolatile = merge(r.status1_nonvolatile, n.sh[7:0], frz ? 8'h00 : SR_WR_MASK);
								n.status1_volatile = merge(r.status1_volatile, n.sh[7:0], frz ? 8'h00 : SR_WR_MASK);
							end else if (r.nbytes == 10'd1) begin
								n.config1_nonvolatile = merge(r.config1_nonvolatile, n.sh[7:0],
									frz ? (CRNV_WR_MASK & ~CRNV_LOCK_MASK) : CRNV_WR_MASK);
								n.config1_volatile = merge(r.config1_volatile, n.sh[7:0],
									frz ? (CRV_WR_MASK & ~CRV_LOCK_MASK) : CRV_WR_MASK);
							end
						end else if (r.nbytes < 10'(PAGE_BYTES)) begin
							buf_we = 1'b1;
							buf_wdata = n.sh[7:0];
							n.bidx = r.bidx + 9'd1;
							n.nbytes = r.nbytes + 10'd1;
						end
					end
				end
				default: ;
			endcase
		end

		if (drv) begin
			case (r.opcode)
				OP_RDSR: src = r.status1_volatile;
				OP_RDCR: src = r.config1_volatile;
				default: src = buf_rdata;
			endcase
			val = (r.cnt == 5'd0) ? src : r.dout;
			if (r.cnt == 5'd0 && r.opcode != OP_RDSR && r.opcode != OP_RDCR) begin
				n.bidx = r.bidx + 9'd1;
			end
			n.dout = val << w;
			n.cnt = (cnt_n == 5'd8) ? 5'd0 : cnt_n;
			case (w)
				3'd4: begin
					n.io_out = val[7:4];
					n.io_oe_n = 4'h0;
				end
				3'd2: begin
					n.io_out = {2'b00, val[7:6]};
					n.io_oe_n = 4'hC;
				end
				default: begin
					n.io_out = {2'b00, val[7], 1'b0};
					n.io_oe_n = 4'hD;
				end
			endcase
		end

		if (r.op_busy) begin
			if (r.op_cnt == OP_CNT_W'(1)) begin
				n.op_busy = 1'b0;
				n.status1_volatile[SR_WIP] = 1'b0;
				ev[IRQ_OP_DONE] = 1'b1;
			end else begin
				n.op_cnt = r.op_cnt - OP_CNT_W'(1);
			end
		end

		// chip select rising ends the command
		if (cs_s & ~r.cs_q) begin
			if (r.armed) begin
				n.status1_volatile[SR_WEL] = 1'b0;
				if (r.opcode == OP_OTPP) begin
					bad = r.fail_next | frz;
				end else begin
					bad = r.fail_next | prot(r.addr, r.status1_volatile[4:2], r.config1_nonvolatile[CR_PRO]);
				end
				if (r.opcode != OP_WRR) begin
					n.status1_volatile[SR_WIP] = 1'b1;
					n.fail_next = 1'b0;
					if (bad && r.opcode == OP_SE) begin
						n.status1_volatile[SR_EERR] = 1'b1;
						ev[IRQ_EERR] = 1'b1;
					end else if (bad) begin
						n.status1_volatile[SR_PERR] = 1'b1;
						ev[IRQ_PERR] = 1'b1;
					end else begin
						n.op_busy = 1'b1;
						n.op_cnt = (r.opcode == OP_SE) ? OP_CNT_W'(ERASE_CYCLES) :
							OP_CNT_W'(PROG_CYCLES);
					end
				end
			end
			n.phase = PH_IDLE;
			n.armed = 1'b0;
			n.io_out = 4'h0;
			n.io_oe_n = 4'hF;
			ev[IRQ_CMD_END] = 1'b1;
		end else if (~cs_s & r.cs_q) begin
			n.phase = PH_INSTR;
			n.cnt = 5'd0;
			n.nbytes = 10'd0;
			n.armed = 1'b0;
		end

		// register bus
		if (r.awready & s_axi_awvalid) begin
			n.aw_held = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (r.wready & s_axi_wvalid) begin
			n.w_held = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (r.bvalid & s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (r.aw_held & r.w_held & ~r.bvalid) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			if (r.awaddr == REG_IRQ_CLEAR) begin
				if (r.wstrb[0]) clr = r.wdata[3:0];
			end else if (r.awaddr == REG_IRQ_ENABLE) begin
				if (r.wstrb[0]) n.irq_en = r.wdata[3:0];
			end else if (r.awaddr == REG_CONTROL) begin
				if (r.wstrb[0]) n.fail_next = r.wdata[0];
			end else begin
				n.bresp = RESP_SLVERR;
			end
		end
		n.awready = ~n.aw_held & ~n.bvalid;
		n.wready = ~n.w_held & ~n.bvalid;

		if (r.rvalid & s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (r.arready & s_axi_arvalid) begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			n.rdata = 32'h00000000;
			if (s_axi_araddr == REG_FLASH_STATUS) begin
				n.rdata = {r.config1_nonvolatile, r.config1_volatile, r.status1_nonvolatile, r.status1_volatile};
			end else if (s_axi_araddr == REG_IRQ_STATUS) begin
				n.rdata = {28'h0000000, r.irq_stat};
			end else if (s_axi_araddr == REG_IRQ_CLEAR) begin
				n.rdata = 32'h00000000;
			end else if (s_axi_araddr == REG_IRQ_ENABLE) begin
				n.rdata = {28'h0000000, r.irq_en};
			end else if (s_axi_araddr == REG_CONTROL) begin
				n.rdata = {30'h00000000, r.op_busy, r.fail_next};
			end else begin
				n.rresp = RESP_SLVERR;
			end
		end
		n.arready = ~n.rvalid;

		// set wins over clear
		n.irq_stat = (r.irq_stat & ~clr) | ev;
		n.irq = |(n.irq_stat & n.irq_en);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.phase <= PH_IDLE;
			r.cs_q <= 1'b1;
			r.io_oe_n <= 4'hF;
			r.status1_volatile <= STATUS1_VOLATILE_RST;
			r.status1_nonvolatile <= STATUS1_NONVOLATILE_RST;
			r.config1_volatile <= CONFIG1_VOLATILE_RST;
			r.config1_nonvolatile <= CONFIG1_NONVOLATILE_RST;
		end else begin
			r <= n;
		end
	end

	assign io_out = r.io_out;
	assign io_oe_n = r.io_oe_n;
	assign irq = r.irq;
	assign s_axi_awready = r.awready;
	assign s_axi_wready = r.wready;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = r.arready;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
endmodule : sfel_flash_ctrl
`default_nettype wire

// file: verilog/sfel_page_buf.sv
`timescale 1ns/1ps
`default_nettype none
module sfel_page_buf #(
	parameter int DEPTH = 512,
	parameter int AW = 9
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [7:0] rdata
);
	typedef struct packed {
		logic [7:0] rdata;
	} sfel_buf_type;
	sfel_buf_type r;
	sfel_buf_type n;
	logic [7:0] mem [DEPTH];

	always_comb begin
		n = r;
		n.rdata = mem[raddr];
	end

	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		if (!aresetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign rdata = r.rdata;
endmodule : sfel_page_buf
`default_nettype wire

// file: verilog/sfel_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sfel_sync #(
	parameter int W = 6,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sfel_sync_type;
	sfel_sync_type r;
	sfel_sync_type n;
	logic [W-1:0] agree;

	always_comb begin
		n = r;
		n.s1 = d;
		n.s2 = r.s1;
		n.s3 = r.s2;
		// a bit moves only when stages two and three agree
		agree = ~(r.s2 ^ r.s3);
		n.q = (agree & r.s3) | (~agree & r.q);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= {RST, RST, RST, RST};
		end else begin
			r <= n;
		end
	end

	assign q = r.q;
endmodule : sfel_sync
`default_nettype wire
